// file: pkg/wer_pkg.sv
package wer_pkg;

  // ----------------------------------------------------------------
  // register indices on the plain port
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_HOST_STATUS = 5'h00;
  localparam logic [4:0] ADDR_HOST_PWR_EN = 5'h02;
  localparam logic [4:0] ADDR_HOST_MGMT_EN = 5'h13;
  localparam logic [4:0] ADDR_HOST_IRQ_EN = 5'h15;
  localparam logic [4:0] ADDR_CORE_STATUS = 5'h08;
  localparam logic [4:0] ADDR_CORE_ROUTE_EN = 5'h09;
  localparam logic [4:0] ADDR_CTL_1 = 5'h0a;
  localparam logic [4:0] ADDR_CTL_2 = 5'h0b;
  localparam logic [4:0] ADDR_CTL_3 = 5'h0c;
  localparam logic [4:0] ADDR_INT_EN_2 = 5'h0d;
  localparam logic [4:0] ADDR_CFG_LOW = 5'h0e;
  localparam logic [4:0] ADDR_CFG_HIGH = 5'h0f;
  localparam logic [4:0] ADDR_PB_OUT = 5'h10;
  localparam logic [4:0] ADDR_PB_ALT = 5'h11;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ALARM_PEND = 5;
  localparam int BIT_RESET_ON_ACCESS = 0;
  localparam int BIT_ALARM_INT_EN = 5;
  localparam int BIT_HOST_RESET_SW = 0;
  localparam int BIT_CFG_VALID = 1;
  localparam int BIT_CFG_LOCK = 2;
  localparam int BIT_SMI_ON_IRQ = 3;
  localparam int BIT_GATE_A20 = 5;
  localparam int BIT_CFG_LOW_MSB = 7;
  localparam int NUM_EVENTS = 8;
  localparam int NUM_STATE_REQ = 5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PB_OUT_RESET = 8'h20;
  localparam logic [7:0] CTL2_MASK = 8'h1f;
  localparam logic [7:0] PB_ALT_MASK = 8'hdf;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wer_bus_s;

endpackage : wer_pkg

// file: rtl/wer_routing.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module wer_routing
  import wer_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire wer_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] event_set_i,
  input wire logic rtc_alarm_i,
  input wire logic [4:0] state_req_i,
  input wire logic pm_chan1_mgmt_i,
  input wire logic pm_chan2_mgmt_i,
  input wire logic cfg_irq_wake_i,
  input wire logic powerup_reset_i,
  input wire logic lpc_start_i,
  output logic power_up_request_n_o,
  output logic mgmt_int_n_o,
  output logic host_irq_o,
  output logic core_wake_interrupt_o,
  output logic cfg_base_valid_o,
  output logic [15:0] cfg_base_o,
  output logic host_fast_reset_n_o,
  output logic gate_addr_line_20_o,
  output logic gate_addr_line_20_oe_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  wire logic wr = bus_i.wr;
  wire logic [7:0] wd = bus_i.wdata;
  wire logic w_hst = wr && hit(bus_i.addr, ADDR_HOST_STATUS);
  wire logic w_hpe = wr && hit(bus_i.addr, ADDR_HOST_PWR_EN);
  wire logic w_hme = wr && hit(bus_i.addr, ADDR_HOST_MGMT_EN);
  wire logic w_hie = wr && hit(bus_i.addr, ADDR_HOST_IRQ_EN);
  wire logic w_cst = wr && hit(bus_i.addr, ADDR_CORE_STATUS);
  wire logic w_cre = wr && hit(bus_i.addr, ADDR_CORE_ROUTE_EN);
  wire logic w_c1 = wr && hit(bus_i.addr, ADDR_CTL_1);
  wire logic w_c2 = wr && hit(bus_i.addr, ADDR_CTL_2);
  wire logic w_c3 = wr && hit(bus_i.addr, ADDR_CTL_3);
  wire logic w_ie2 = wr && hit(bus_i.addr, ADDR_INT_EN_2);
  wire logic w_lo = wr && hit(bus_i.addr, ADDR_CFG_LOW);
  wire logic w_hi = wr && hit(bus_i.addr, ADDR_CFG_HIGH);
  wire logic w_pb = wr && hit(bus_i.addr, ADDR_PB_OUT);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] host_event_status;
  logic [7:0] core_event_status;
  logic [7:0] host_powerup_route_en;
  logic [7:0] host_mgmt_int_route_en;
  logic [7:0] host_irq_route_en;
  logic [7:0] core_wake_route_en;
  logic [7:0] core_ctl_status_1;
  logic [7:0] core_ctl_status_2;
  logic [7:0] core_ctl_status_3;
  logic [7:0] core_int_enable_2;
  logic [7:0] cfg_base_low_byte;
  logic [7:0] cfg_base_high_byte;
  logic [7:0] port_b_data_out;
  logic alarm_d;

  wire logic alarm_rise = rtc_alarm_i && !alarm_d;
  wire logic cfg_lock = core_ctl_status_1[BIT_CFG_LOCK];

  // ----------------------------------------------------------------
  // status next values
  // ----------------------------------------------------------------

  // set wins over clear, one flop per status bit
  logic [7:0] next_host_status;
  logic [7:0] next_core_status;
  logic [7:0] next_ctl2;
  genvar g;
  generate
    for (g = 0; g < NUM_EVENTS; g++)
    begin : g_stat
      assign next_host_status[g] = event_set_i[g] |
        (host_event_status[g] & ~(w_hst & wd[g]));
      assign next_core_status[g] = event_set_i[g] |
        (core_event_status[g] & ~(w_cst & wd[g]));
      assign next_ctl2[g] = (g < NUM_STATE_REQ) ? (state_req_i[g % NUM_STATE_REQ] |
        (core_ctl_status_2[g] & ~(w_c2 & wd[g]))) : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // rtc alarm pending
  // ----------------------------------------------------------------

  wire logic next_alarm = alarm_rise |
    (core_ctl_status_3[BIT_ALARM_PEND] & ~(w_c3 & wd[BIT_ALARM_PEND]));

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------

  logic [7:0] next_ctl3;
  always_comb
  begin
    next_ctl3 = core_ctl_status_3;
    if (w_c3)
    begin
      next_ctl3[BIT_RESET_ON_ACCESS] = wd[BIT_RESET_ON_ACCESS];
    end
    next_ctl3[BIT_ALARM_PEND] = next_alarm;
  end

  logic [7:0] next_ctl1;
  always_comb
  begin
    next_ctl1 = core_ctl_status_1;
    if (w_c1)
    begin
      next_ctl1[BIT_HOST_RESET_SW] = wd[BIT_HOST_RESET_SW];
      next_ctl1[BIT_SMI_ON_IRQ] = wd[BIT_SMI_ON_IRQ];
      if (wd[BIT_CFG_VALID])
      begin
        next_ctl1[BIT_CFG_VALID] = 1'b0;
        next_ctl1[BIT_CFG_LOCK] = 1'b0;
      end
      if (wd[BIT_CFG_LOCK])
      begin
        next_ctl1[BIT_CFG_LOCK] = 1'b1;
        next_ctl1[BIT_CFG_VALID] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output combine
  // ----------------------------------------------------------------
  wire logic pwr_any = |(host_event_status & host_powerup_route_en);
  wire logic mgmt_any = |(host_event_status & host_mgmt_int_route_en);
  wire logic irq_any = |(host_event_status & host_irq_route_en);
  wire logic mgmt_req = mgmt_any | pm_chan1_mgmt_i | pm_chan2_mgmt_i;
  wire logic smi_irq = core_ctl_status_1[BIT_SMI_ON_IRQ];
  wire logic core_any = |(core_event_status & core_wake_route_en) |
    |(core_ctl_status_2 & core_int_enable_2 & CTL2_MASK) |
    (core_ctl_status_3[BIT_ALARM_PEND] & core_int_enable_2[BIT_ALARM_INT_EN]);
  wire logic kb_low = core_ctl_status_1[BIT_HOST_RESET_SW] |
    (powerup_reset_i & core_ctl_status_3[BIT_RESET_ON_ACCESS] & lpc_start_i);

  // ----------------------------------------------------------------
  // read select
  // ----------------------------------------------------------------

  logic [7:0] rd_mux;
  always_comb
  begin
    case (bus_i.addr)
      ADDR_HOST_STATUS: rd_mux = host_event_status;
      ADDR_HOST_PWR_EN: rd_mux = host_powerup_route_en;
      ADDR_HOST_MGMT_EN: rd_mux = host_mgmt_int_route_en;
      ADDR_HOST_IRQ_EN: rd_mux = host_irq_route_en;
      ADDR_CORE_STATUS: rd_mux = core_event_status;
      ADDR_CORE_ROUTE_EN: rd_mux = core_wake_route_en;
      ADDR_CTL_1: rd_mux = core_ctl_status_1;
      ADDR_CTL_2: rd_mux = core_ctl_status_2;
      ADDR_CTL_3: rd_mux = core_ctl_status_3;
      ADDR_INT_EN_2: rd_mux = core_int_enable_2;
      ADDR_CFG_LOW: rd_mux = cfg_base_low_byte;
      ADDR_CFG_HIGH: rd_mux = cfg_base_high_byte;
      ADDR_PB_OUT: rd_mux = port_b_data_out;
      ADDR_PB_ALT: rd_mux = BYTE_ZERO;
      default: rd_mux = BYTE_ZERO;
    endcase
  end
  wire logic [7:0] next_rdata = bus_i.rd ? rd_mux : BYTE_ZERO;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      host_event_status <= BYTE_ZERO;
      core_event_status <= BYTE_ZERO;
      host_powerup_route_en <= BYTE_ZERO;
      host_mgmt_int_route_en <= BYTE_ZERO;
      host_irq_route_en <= BYTE_ZERO;
      core_wake_route_en <= BYTE_ZERO;
      core_ctl_status_1 <= BYTE_ZERO;
      core_ctl_status_2 <= BYTE_ZERO;
      core_ctl_status_3 <= BYTE_ZERO;
      core_int_enable_2 <= BYTE_ZERO;
      alarm_d <= 1'b0;
    end
    else
    begin
      host_event_status <= next_host_status;
      core_event_status <= next_core_status;
      core_ctl_status_1 <= next_ctl1;
      core_ctl_status_2 <= next_ctl2;
      core_ctl_status_3 <= next_ctl3;
      alarm_d <= rtc_alarm_i;
      if (w_hpe)
        host_powerup_route_en <= wd;
      if (w_hme)
        host_mgmt_int_route_en <= wd;
      if (w_hie)
        host_irq_route_en <= wd;
      if (w_cre)
        core_wake_route_en <= wd;
      if (w_ie2)
        core_int_enable_2 <= wd;
    end
  end

  // ----------------------------------------------------------------
  // config base and port b
  // ----------------------------------------------------------------

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cfg_base_low_byte <= BYTE_ZERO;
      cfg_base_high_byte <= BYTE_ZERO;
      port_b_data_out <= PB_OUT_RESET;
    end
    else
    begin
      if (w_lo && !cfg_lock)
        cfg_base_low_byte <= {1'b0, wd[BIT_CFG_LOW_MSB-1:0]};
      if (w_hi && !cfg_lock)
        cfg_base_high_byte <= wd;
      if (w_pb)
        port_b_data_out <= wd;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rdata_o <= BYTE_ZERO;
      power_up_request_n_o <= 1'b1;
      mgmt_int_n_o <= 1'b1;
      host_irq_o <= 1'b0;
      core_wake_interrupt_o <= 1'b0;
      cfg_base_valid_o <= 1'b0;
      cfg_base_o <= {BYTE_ZERO, BYTE_ZERO};
      host_fast_reset_n_o <= 1'b1;
      gate_addr_line_20_o <= 1'b1;
      gate_addr_line_20_oe_o <= 1'b1;
    end
    else
    begin
      rdata_o <= next_rdata;
      power_up_request_n_o <= ~(pwr_any | cfg_irq_wake_i);
      mgmt_int_n_o <= ~(mgmt_req & ~smi_irq);
      host_irq_o <= irq_any | (mgmt_req & smi_irq);
      core_wake_interrupt_o <= core_any;
      cfg_base_valid_o <= core_ctl_status_1[BIT_CFG_VALID];
      cfg_base_o <= {cfg_base_high_byte, cfg_base_low_byte};
      host_fast_reset_n_o <= ~kb_low;
      gate_addr_line_20_o <= port_b_data_out[BIT_GATE_A20];
      gate_addr_line_20_oe_o <= 1'b1;
    end
  end

endmodule : wer_routing

// file: sim/wer_routing_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// output checks
// ----------------------------------------------------------------
module wer_routing_asserts
  import wer_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire wer_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic pm_chan1_mgmt_i,
  input wire logic pm_chan2_mgmt_i,
  input wire logic cfg_irq_wake_i,
  input wire logic power_up_request_n_o,
  input wire logic mgmt_int_n_o,
  input wire logic host_irq_o,
  input wire logic cfg_base_valid_o,
  input wire logic host_fast_reset_n_o,
  input wire logic gate_addr_line_20_o,
  input wire logic gate_addr_line_20_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence ctl1_wr(int b);
    bus_i.wr && bus_i.addr == ADDR_CTL_1 && bus_i.wdata == (8'h01 << b);
  endsequence
  sequence pb_wr;
    bus_i.wr && bus_i.addr == ADDR_PB_OUT;
  endsequence
  rst_idle_a: assert property (disable iff (1'b0) srst_i |=>
    power_up_request_n_o && mgmt_int_n_o && !host_irq_o && host_fast_reset_n_o)
    else $error("outputs not idle in reset");
  pm_mgmt_a: assert property ((pm_chan1_mgmt_i || pm_chan2_mgmt_i) |-> ##[1:2]
    (!mgmt_int_n_o || host_irq_o)) else $error("pm request not routed");
  cfg_wake_a: assert property (cfg_irq_wake_i |-> ##[1:2] !power_up_request_n_o)
    else $error("wake request not routed");
  sw_reset_a: assert property (ctl1_wr(BIT_HOST_RESET_SW) |-> ##[1:2]
    !host_fast_reset_n_o) else $error("fast reset not driven");
  valid_clr_a: assert property (ctl1_wr(BIT_CFG_VALID) |-> ##[1:2]
    !cfg_base_valid_o) else $error("valid not cleared");
  lock_set_a: assert property (ctl1_wr(BIT_CFG_LOCK) |-> ##[1:2]
    cfg_base_valid_o) else $error("valid not set by lock");
  a20_follow_a: assert property (pb_wr |-> ##2
    gate_addr_line_20_o == $past(bus_i.wdata[BIT_GATE_A20], 2)) else $error("a20 wrong");
  oe_high_a: assert property (gate_addr_line_20_oe_o)
    else $error("a20 not driven");
  alt_zero_a: assert property (bus_i.rd && bus_i.addr == ADDR_PB_ALT |=>
    !rdata_o[BIT_GATE_A20]) else $error("alt bit reads one");
endmodule : wer_routing_asserts
bind wer_routing wer_routing_asserts chk (.clock_i, .srst_i, .bus_i, .rdata_o, .pm_chan1_mgmt_i,
  .pm_chan2_mgmt_i, .cfg_irq_wake_i, .power_up_request_n_o, .mgmt_int_n_o, .host_irq_o,
  .cfg_base_valid_o, .host_fast_reset_n_o, .gate_addr_line_20_o, .gate_addr_line_20_oe_o);

// file: sim/wer_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// rtc alarm flag and chipset requests
// ----------------------------------------------------------------
module wer_far_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic alarm_set_i,
  input wire logic alarm_clr_i,
  input wire logic [2:0] req_i,
  output logic rtc_alarm_o,
  output logic pm_chan1_mgmt_o,
  output logic pm_chan2_mgmt_o,
  output logic cfg_irq_wake_o
);
  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      rtc_alarm_o <= 1'b0;
      {cfg_irq_wake_o, pm_chan2_mgmt_o, pm_chan1_mgmt_o} <= 3'h0;
    end
    else
    begin
      rtc_alarm_o <= alarm_set_i | (rtc_alarm_o & ~alarm_clr_i);
      {cfg_irq_wake_o, pm_chan2_mgmt_o, pm_chan1_mgmt_o} <= req_i;
    end
endmodule : wer_far_model

// file: sim/wer_routing_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module wer_routing_test
  import wer_pkg::*;
;
  logic clock_i, srst_i, a_set, a_clr, powerup_reset_i, lpc_start_i, rtc_alarm_i;
  logic pm_chan1_mgmt_i, pm_chan2_mgmt_i, cfg_irq_wake_i, power_up_request_n_o, mgmt_int_n_o;
  logic host_irq_o, core_wake_interrupt_o, cfg_base_valid_o, host_fast_reset_n_o;
  logic gate_addr_line_20_o, gate_addr_line_20_oe_o;
  logic [2:0] req;
  logic [4:0] state_req_i;
  logic [7:0] event_set_i, rdata_o, d;
  logic [15:0] cfg_base_o;
  wer_bus_s bus_i;
  int mismatches, checks_done;
  wire [2:0] outs = {host_irq_o, ~mgmt_int_n_o, ~power_up_request_n_o};
  wer_routing DUT (.clock_i, .srst_i, .bus_i, .rdata_o, .event_set_i, .rtc_alarm_i,
    .state_req_i, .pm_chan1_mgmt_i, .pm_chan2_mgmt_i, .cfg_irq_wake_i, .powerup_reset_i,
    .lpc_start_i, .power_up_request_n_o, .mgmt_int_n_o, .host_irq_o, .core_wake_interrupt_o,
    .cfg_base_valid_o, .cfg_base_o, .host_fast_reset_n_o, .gate_addr_line_20_o,
    .gate_addr_line_20_oe_o);
  wer_far_model far (.clock_i, .srst_i, .alarm_set_i(a_set), .alarm_clr_i(a_clr), .req_i(req),
    .rtc_alarm_o(rtc_alarm_i), .pm_chan1_mgmt_o(pm_chan1_mgmt_i),
    .pm_chan2_mgmt_o(pm_chan2_mgmt_i), .cfg_irq_wake_o(cfg_irq_wake_i));
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic t_route;
    logic [4:0] regs [3] = '{ADDR_HOST_PWR_EN, ADDR_HOST_MGMT_EN, ADDR_HOST_IRQ_EN};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_i) event_set_i <= 8'h01;
      @(posedge clock_i) event_set_i <= 8'h00;
      settle;
      `CHK(outs, 3'h0)
      wr(regs[i], 8'h01);
      settle;
      `CHK(outs, 3'h1 << i)
      wr(regs[i], 8'h00);
      settle;
      `CHK(outs, 3'h0)
      rd(ADDR_HOST_STATUS);
      `CHK(d, 8'h01)
      wr(regs[i], 8'h01);
      wr(ADDR_HOST_STATUS, 8'h00);
      settle;
      `CHK(outs, 3'h1 << i)
      wr(ADDR_HOST_STATUS, 8'h01);
      settle;
      `CHK(outs, 3'h0)
      wr(regs[i], 8'h00);
      wr(ADDR_CORE_STATUS, 8'h01);
    end
    $display("route test done");
  endtask : t_route
  task automatic t_core;
    @(posedge clock_i) event_set_i <= 8'h04;
    @(posedge clock_i) event_set_i <= 8'h00;
    wr(ADDR_CORE_ROUTE_EN, 8'h04);
    settle;
    `CHK(core_wake_interrupt_o, 1'b1)
    wr(ADDR_HOST_STATUS, 8'h04);
    settle;
    `CHK(core_wake_interrupt_o, 1'b1)
    wr(ADDR_CORE_STATUS, 8'h04);
    settle;
    `CHK(core_wake_interrupt_o, 1'b0)
    @(posedge clock_i) a_set <= 1'b1;
    @(posedge clock_i) a_set <= 1'b0;
    settle;
    rd(ADDR_CTL_3);
    `CHK(d, 8'h20)
    `CHK(core_wake_interrupt_o, 1'b0)
    wr(ADDR_INT_EN_2, 8'h20);
    settle;
    `CHK(core_wake_interrupt_o, 1'b1)
    wr(ADDR_CTL_3, 8'h20);
    @(posedge clock_i) a_clr <= 1'b1;
    @(posedge clock_i) a_clr <= 1'b0;
    settle;
    `CHK(core_wake_interrupt_o, 1'b0)
    wr(ADDR_INT_EN_2, 8'h21);
    @(posedge clock_i) state_req_i <= 5'h01;
    @(posedge clock_i) state_req_i <= 5'h00;
    settle;
    `CHK(core_wake_interrupt_o, 1'b1)
    wr(ADDR_CTL_2, 8'h01);
    settle;
    `CHK(core_wake_interrupt_o, 1'b0)
    $display("core test done");
  endtask : t_core
  task automatic t_pm;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_i) req <= 3'h1 << i;
      settle;
      `CHK(outs[1:0], (i == 2) ? 2'h1 : 2'h2)
      @(posedge clock_i) req <= 3'h0;
    end
    wr(ADDR_CTL_1, 8'h08);
    @(posedge clock_i) req <= 3'h1;
    settle;
    `CHK(host_irq_o, 1'b1)
    `CHK(mgmt_int_n_o, 1'b1)
    @(posedge clock_i) req <= 3'h0;
    wr(ADDR_CTL_1, 8'h00);
    $display("pm test done");
  endtask : t_pm
  task automatic t_misc;
    wr(ADDR_CTL_1, 8'h02);
    wr(ADDR_CFG_LOW, 8'hff);
    wr(ADDR_CFG_HIGH, 8'h12);
    settle;
    `CHK(cfg_base_valid_o, 1'b0)
    wr(ADDR_CTL_1, 8'h04);
    wr(ADDR_CFG_LOW, 8'h00);
    settle;
    `CHK({cfg_base_valid_o, cfg_base_o}, 17'h1127f)
    wr(ADDR_CTL_1, 8'h01);
    settle;
    `CHK(host_fast_reset_n_o, 1'b0)
    wr(ADDR_CTL_1, 8'h00);
    settle;
    `CHK(host_fast_reset_n_o, 1'b1)
    wr(ADDR_CTL_3, 8'h01);
    @(posedge clock_i) {powerup_reset_i, lpc_start_i} <= 2'h3;
    settle;
    `CHK(host_fast_reset_n_o, 1'b0)
    @(posedge clock_i) {powerup_reset_i, lpc_start_i} <= 2'h0;
    wr(ADDR_PB_OUT, 8'h00);
    settle;
    `CHK(gate_addr_line_20_o, 1'b0)
    `CHK(gate_addr_line_20_oe_o, 1'b1)
    wr(ADDR_PB_ALT, 8'hff);
    rd(ADDR_PB_ALT);
    `CHK(d[BIT_GATE_A20], 1'b0)
    rd(5'h1f);
    `CHK(d, BYTE_ZERO)
    $display("misc test done");
  endtask : t_misc
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial
  begin
    #(3000 * 100);
    mismatches++;
    give_verdict;
  end
  initial
  begin
    {srst_i, a_set, a_clr, powerup_reset_i, lpc_start_i} = 5'h10;
    {bus_i, event_set_i, state_req_i, req} = '0;
    repeat (12) @(posedge clock_i);
    `CHK({outs, core_wake_interrupt_o, gate_addr_line_20_o, host_fast_reset_n_o}, 6'h3)
    srst_i <= 1'b0;
    rd(ADDR_PB_OUT);
    `CHK(d, PB_OUT_RESET)
    t_route;
    t_core;
    t_pm;
    t_misc;
    give_verdict;
  end
endmodule : wer_routing_test
